/* hw/dp_cfg_pkg.sv */
// Purpose: Shared constants for the fieldbus slave exchange configuration block
// Assumes: 100 MHz clock, word-wide exchange data
// Notes: Identifier bytes follow the configuration identifier byte layout
package dp_cfg_pkg;
   localparam int WORD_W = 16;
   localparam int FIFO_DEPTH = 8;
   localparam int ADDR_W = 7;
   // Identifier byte fields
   localparam int ID_LEN_LSB = 0;
   localparam int ID_LEN_MSB = 3;
   localparam int ID_DIR_LSB = 4;
   localparam int ID_DIR_MSB = 5;
   localparam int ID_WORD_BIT = 6;
   localparam int ID_CONS_BIT = 7;
   localparam logic [7:0] ID_IN5 = 8'hD4;
   localparam logic [7:0] ID_OUT1 = 8'hE0;
   localparam logic [7:0] ID_OUT12 = 8'hEB;
   localparam logic [3:0] LEN_CODE_12 = 4'b1011;
   localparam logic [3:0] LEN_CODE_5 = 4'b0100;
   // Layout word counts
   localparam logic [5:0] IN_WORDS = 6'd5;
   localparam logic [5:0] OUT_WORDS_FULL = 6'd37;
   localparam logic [5:0] OUT_WORDS_SHORT = 6'd13;
   localparam logic [5:0] OMIT_WORDS = 6'd12;
   // Full layout: D4, EB, EB, EB, E0 ; short: D4, E0, EB
   localparam logic [2:0] CFG_LEN_FULL = 3'd5;
   localparam logic [2:0] CFG_LEN_SHORT = 3'd3;
   // Arbitrary identification value, not taken from any real part
   localparam logic [15:0] SLAVE_IDENT = 16'h0A5C;
   typedef enum logic [1:0] {LAYOUT_NONE, LAYOUT_FULL, LAYOUT_SHORT} layout_e;
endpackage

/* hw/word_fifo.sv */
// Purpose: Synchronous FIFO with valid/ready on both sides
// Assumes: Single clock
// Notes: Full and empty come from an occupancy count
`timescale 1ns/1ns
module word_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] inData,
   input wire logic inValid,
   output logic inReady,
   output logic [WIDTH-1:0] outData,
   output logic outValid,
   input wire logic outReady
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
   logic [PW:0] count_q, count_d;
   logic doWr, doRd;

   always_comb begin
      inReady = (count_q != (PW+1)'(DEPTH));
      outValid = (count_q != '0);
      outData = mem_q[rdPtr_q];
      doWr = inValid && inReady;
      doRd = outValid && outReady;
      wrPtr_d = doWr ? ((wrPtr_q == PW'(DEPTH - 1)) ? '0 : wrPtr_q + 1'b1) : wrPtr_q;
      rdPtr_d = doRd ? ((rdPtr_q == PW'(DEPTH - 1)) ? '0 : rdPtr_q + 1'b1) : rdPtr_q;
      count_d = count_q + (PW+1)'(doWr) - (PW+1)'(doRd);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
         count_q <= '0;
      end else begin
         wrPtr_q <= wrPtr_d;
         rdPtr_q <= rdPtr_d;
         count_q <= count_d;
      end
   end

   always_ff @(posedge clk) begin
      if (doWr) begin
         mem_q[wrPtr_q] <= inData;
      end
   end
endmodule

/* hw/fieldbus_slave_exchange_config.sv */
// Purpose: Slave-side configuration check and cyclic word exchange steering
// Assumes: Telegram framing done upstream; requests arrive as decoded strobes
// Notes: Output words pass an 8-word FIFO to the regulation side
`timescale 1ns/1ns
module fieldbus_slave_exchange_config
   import dp_cfg_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [dp_cfg_pkg::ADDR_W-1:0] addrSwitch,
   input wire logic reqValid,
   input wire logic [dp_cfg_pkg::ADDR_W-1:0] reqAddr,
   input wire logic reqIsCfg,
   input wire logic reqIsData,
   input wire logic reqIsIdent,
   input wire logic cfgValid,
   input wire logic [7:0] cfgByte,
   input wire logic cfgLast,
   input wire logic outWordValid,
   input wire logic [dp_cfg_pkg::WORD_W-1:0] outWord,
   output logic outWordReady,
   input wire logic [dp_cfg_pkg::WORD_W-1:0] inWord,
   output logic inWordTake,
   output logic respValid,
   output logic respAck,
   output logic [dp_cfg_pkg::WORD_W-1:0] respData,
   output logic respLast,
   output logic [dp_cfg_pkg::ADDR_W-1:0] stationAddr,
   output logic [1:0] activeLayout,
   output logic useStoredLampValues,
   output logic busLedGreen,
   output logic [dp_cfg_pkg::WORD_W-1:0] regWord,
   output logic regWordValid,
   input wire logic regWordReady
);
   import dp_cfg_pkg::*;

   typedef enum logic [1:0] {ST_IDLE, ST_IN, ST_OUT} xfer_e;

   logic [ADDR_W-1:0] addr1_q, addr2_q, addr3_q, stationAddr_q, stationAddr_d;
   logic [2:0] syncFill_q;
   logic addrTaken_q, addrTaken_d;
   logic [2:0] cfgIdx_q, cfgIdx_d;
   logic cfgFullOk_q, cfgFullOk_d, cfgShortOk_q, cfgShortOk_d;
   layout_e layout_q, layout_d;
   xfer_e st_q, st_d;
   logic [5:0] wordCnt_q, wordCnt_d;
   logic [5:0] outNeed_q, outNeed_d;
   logic led_q, led_d;
   logic respValid_q, respValid_d, respAck_q, respAck_d, respLast_q, respLast_d;
   logic [WORD_W-1:0] respData_q, respData_d;
   logic inTake_q, inTake_d;
   logic forMe, fullByte, shortByte, fifoInReady;
   logic [7:0] fullExp, shortExp;

   // Synchroniser on the rotary switches
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         addr1_q <= '0;
         addr2_q <= '0;
         addr3_q <= '0;
         syncFill_q <= '0;
      end else begin
         syncFill_q <= {syncFill_q[1:0], 1'b1};
         addr1_q <= addrSwitch;
         addr2_q <= addr1_q;
         addr3_q <= addr2_q;
      end
   end

   // Expected identifier byte sequences
   always_comb begin
      case (cfgIdx_q)
         3'd0: fullExp = ID_IN5;
         3'd4: fullExp = ID_OUT1;
         default: fullExp = ID_OUT12;
      endcase
      case (cfgIdx_q)
         3'd0: shortExp = ID_IN5;
         3'd1: shortExp = ID_OUT1;
         default: shortExp = ID_OUT12;
      endcase
   end

   always_comb begin
      forMe = reqValid && (reqAddr == stationAddr_q) && addrTaken_q;
      fullByte = (cfgByte == fullExp) && (cfgIdx_q < CFG_LEN_FULL);
      shortByte = (cfgByte == shortExp) && (cfgIdx_q < CFG_LEN_SHORT);
      stationAddr_d = stationAddr_q;
      addrTaken_d = addrTaken_q;
      // Catch once, only after synchroniser agrees after power-up
      // Reset values of the stages agree as well, so wait until all three are filled
      if (!addrTaken_q && syncFill_q[2] && (addr2_q == addr3_q)) begin
         stationAddr_d = addr3_q;
         addrTaken_d = 1'b1;
      end
      cfgIdx_d = cfgIdx_q;
      cfgFullOk_d = cfgFullOk_q;
      cfgShortOk_d = cfgShortOk_q;
      layout_d = layout_q;
      if (forMe && reqIsCfg) begin
         cfgIdx_d = '0;
         cfgFullOk_d = 1'b1;
         cfgShortOk_d = 1'b1;
         layout_d = LAYOUT_NONE;
      end else if (cfgValid) begin
         cfgFullOk_d = cfgFullOk_q && fullByte;
         cfgShortOk_d = cfgShortOk_q && shortByte;
         cfgIdx_d = cfgIdx_q + 3'd1;
         if (cfgLast) begin
            // Layout chosen by configuration; mismatch holds off exchange
            if (cfgFullOk_q && fullByte && (cfgIdx_q == CFG_LEN_FULL - 3'd1)) begin
               layout_d = LAYOUT_FULL;
            end else if (cfgShortOk_q && shortByte && (cfgIdx_q == CFG_LEN_SHORT - 3'd1)) begin
               layout_d = LAYOUT_SHORT;
            end else begin
               layout_d = LAYOUT_NONE;
            end
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stationAddr_q <= '0;
         addrTaken_q <= 1'b0;
         cfgIdx_q <= '0;
         cfgFullOk_q <= 1'b0;
         cfgShortOk_q <= 1'b0;
         layout_q <= LAYOUT_NONE;
      end else begin
         stationAddr_q <= stationAddr_d;
         addrTaken_q <= addrTaken_d;
         cfgIdx_q <= cfgIdx_d;
         cfgFullOk_q <= cfgFullOk_d;
         cfgShortOk_q <= cfgShortOk_d;
         layout_q <= layout_d;
      end
   end

   // Exchange sequencer: input words out, then output words into FIFO
   always_comb begin
      st_d = st_q;
      wordCnt_d = wordCnt_q;
      outNeed_d = outNeed_q;
      led_d = led_q;
      respValid_d = 1'b0;
      respAck_d = 1'b0;
      respLast_d = 1'b0;
      respData_d = respData_q;
      inTake_d = 1'b0;
      outWordReady = 1'b0;
      case (st_q)
         ST_IDLE: begin
            if (forMe && reqIsIdent) begin
               respValid_d = 1'b1;
               respAck_d = 1'b1;
               respLast_d = 1'b1;
               respData_d = SLAVE_IDENT;
            end else if (forMe && reqIsCfg) begin
               respValid_d = 1'b1;
               respAck_d = 1'b1;
               respLast_d = 1'b1;
               respData_d = '0;
            end else if (forMe && reqIsData) begin
               respValid_d = 1'b1;
               if (layout_q == LAYOUT_NONE) begin
                  respAck_d = 1'b0;
                  respLast_d = 1'b1;
                  respData_d = '0;
               end else begin
                  respAck_d = 1'b1;
                  respData_d = inWord;
                  inTake_d = 1'b1;
                  wordCnt_d = 6'd1;
                  st_d = (IN_WORDS == 6'd1) ? ST_OUT : ST_IN;
                  outNeed_d = (layout_q == LAYOUT_FULL) ? OUT_WORDS_FULL : OUT_WORDS_SHORT;
               end
            end
         end
         ST_IN: begin
            respValid_d = 1'b1;
            respAck_d = 1'b1;
            respData_d = inWord;
            inTake_d = 1'b1;
            wordCnt_d = wordCnt_q + 6'd1;
            if (wordCnt_q == IN_WORDS - 6'd1) begin
               respLast_d = 1'b1;
               wordCnt_d = '0;
               st_d = ST_OUT;
            end
         end
         ST_OUT: begin
            outWordReady = fifoInReady;
            if (outWordValid && fifoInReady) begin
               wordCnt_d = wordCnt_q + 6'd1;
               if (wordCnt_q == outNeed_q - 6'd1) begin
                  wordCnt_d = '0;
                  st_d = ST_IDLE;
                  led_d = 1'b1;
               end
            end
         end
         default: st_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= ST_IDLE;
         wordCnt_q <= '0;
         outNeed_q <= '0;
         led_q <= 1'b0;
         respValid_q <= 1'b0;
         respAck_q <= 1'b0;
         respLast_q <= 1'b0;
         respData_q <= '0;
         inTake_q <= 1'b0;
      end else begin
         st_q <= st_d;
         wordCnt_q <= wordCnt_d;
         outNeed_q <= outNeed_d;
         led_q <= led_d;
         respValid_q <= respValid_d;
         respAck_q <= respAck_d;
         respLast_q <= respLast_d;
         respData_q <= respData_d;
         inTake_q <= inTake_d;
      end
   end

   word_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_out_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .inData(outWord),
      .inValid(outWordValid && (st_q == ST_OUT)),
      .inReady(fifoInReady),
      .outData(regWord),
      .outValid(regWordValid),
      .outReady(regWordReady)
   );

   always_comb begin
      respValid = respValid_q;
      respAck = respAck_q;
      respLast = respLast_q;
      respData = respData_q;
      inWordTake = inTake_q;
      stationAddr = stationAddr_q;
      activeLayout = layout_q;
      useStoredLampValues = (layout_q == LAYOUT_SHORT);
      busLedGreen = led_q;
   end
endmodule

/* tb/dp_master_model.sv */
// Purpose: Bus master model that polls the slave block
// Assumes: Requests already decoded into strobes
// Notes: Released data lines show inverted values
`timescale 1ns/1ns
module dp_master_model
   import dp_cfg_pkg::*;
(
   input wire logic clk,
   input wire logic outWordReady,
   output logic reqValid,
   output logic [dp_cfg_pkg::ADDR_W-1:0] reqAddr,
   output logic reqIsCfg,
   output logic reqIsData,
   output logic reqIsIdent,
   output logic cfgValid,
   output logic [7:0] cfgByte,
   output logic cfgLast,
   output logic outWordValid,
   output logic [dp_cfg_pkg::WORD_W-1:0] outWord
);
   logic [15:0] seq;
   initial begin
      {reqValid, reqAddr, reqIsCfg, reqIsData, reqIsIdent} = '0;
      {cfgValid, cfgByte, cfgLast, outWordValid, outWord} = '0;
      seq = 16'h0000;
   end
   // Only the master opens traffic
   task automatic request(input logic [2:0] kind, input logic [6:0] a);
      @(posedge clk);
      reqValid <= 1'b1;
      reqAddr <= a;
      {reqIsCfg, reqIsData, reqIsIdent} <= kind;
      @(posedge clk);
      reqValid <= 1'b0;
   endtask
   task automatic configure(input logic [6:0] a, input logic [7:0] b[5], input int n);
      request(3'b100, a);
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         cfgValid <= 1'b1;
         cfgByte <= b[i];
         cfgLast <= (i == n - 1);
      end
      @(posedge clk);
      cfgValid <= 1'b0;
      cfgByte <= ~cfgByte;
   endtask
   task automatic sendWords(input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         outWordValid <= 1'b1;
         outWord <= 16'h1000 + seq;
         seq = seq + 16'h0001;
         do @(posedge clk); while (!outWordReady);
         outWordValid <= 1'b0;
         outWord <= ~outWord;
      end
   endtask
endmodule

/* tb/fieldbus_slave_exchange_config_properties.sv */
// Purpose: Port checks of the exchange configuration block
// Assumes: One clock, async active-low reset
// Notes: Bound onto the top module
`timescale 1ns/1ns
module exchange_cfg_checker
   import dp_cfg_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic reqValid,
   input wire logic [dp_cfg_pkg::ADDR_W-1:0] reqAddr,
   input wire logic reqIsData,
   input wire logic reqIsIdent,
   input wire logic respValid,
   input wire logic respAck,
   input wire logic [dp_cfg_pkg::WORD_W-1:0] respData,
   input wire logic respLast,
   input wire logic [dp_cfg_pkg::ADDR_W-1:0] stationAddr,
   input wire logic [1:0] activeLayout,
   input wire logic useStoredLampValues,
   input wire logic busLedGreen,
   input wire logic inWordTake
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_foreign;
      reqValid && reqAddr != stationAddr && !respValid |=> !respValid;
   endproperty
   a_foreign: assert property (p_foreign) else $error("answer to a foreign station");
   property p_burst;
      $rose(respValid) && respAck && $past(reqIsData) |-> (respValid && !respLast)[*4] ##1 (respValid && respLast);
   endproperty
   a_burst: assert property (p_burst) else $error("input burst not five words");
   property p_refuse;
      $rose(respValid) && $past(reqIsData) && activeLayout == LAYOUT_NONE |-> !respAck && respLast;
   endproperty
   a_refuse: assert property (p_refuse) else $error("exchange without layout");
   property p_ident;
      $rose(respValid) && $past(reqIsIdent) |-> respAck && respData == SLAVE_IDENT;
   endproperty
   a_ident: assert property (p_ident) else $error("wrong identification");
   property p_stored;
      useStoredLampValues == (activeLayout == LAYOUT_SHORT);
   endproperty
   a_stored: assert property (p_stored) else $error("stored values flag wrong");
   property p_take;
      inWordTake |-> respValid && respAck;
   endproperty
   a_take: assert property (p_take) else $error("input taken outside answer");
   property p_ledStick;
      busLedGreen |=> busLedGreen;
   endproperty
   a_ledStick: assert property (p_ledStick) else $error("indicator dropped");
   property p_ledCause;
      $rose(busLedGreen) |-> activeLayout != LAYOUT_NONE;
   endproperty
   a_ledCause: assert property (p_ledCause) else $error("indicator without layout");
   property p_addr;
      busLedGreen |-> $stable(stationAddr);
   endproperty
   a_addr: assert property (p_addr) else $error("station address moved");
   c_led: cover property ($rose(busLedGreen));
   c_short: cover property (activeLayout == LAYOUT_SHORT && respLast);
   c_refuse: cover property (respValid && !respAck);
endmodule
bind fieldbus_slave_exchange_config exchange_cfg_checker i_chk (.*);

/* tb/tb_top.sv */
// Purpose: Self-checking bench for the exchange configuration block
// Assumes: 100 MHz clock
// Notes: Regulation side stalls to fill the FIFO
`timescale 1ns/1ns
module tb_top;
   import dp_cfg_pkg::*;
   localparam logic [6:0] ST = 7'h15;
   logic clk, rst_n, reqValid, reqIsCfg, reqIsData, reqIsIdent, cfgValid, cfgLast, outWordValid;
   logic outWordReady, inWordTake, respValid, respAck, respLast, useStoredLampValues;
   logic busLedGreen, regWordValid, regWordReady;
   logic [6:0] addrSwitch, reqAddr, stationAddr;
   logic [7:0] cfgByte;
   logic [15:0] outWord, inWord, respData, regWord, firstData;
   logic [1:0] activeLayout;
   logic lastAck;
   int mismatches = 0, samplesChecked = 0, rxCount = 0, takes = 0, nResp;
   fieldbus_slave_exchange_config i_dut (.clk(clk), .rst_n(rst_n), .addrSwitch(addrSwitch),
      .reqValid(reqValid), .reqAddr(reqAddr), .reqIsCfg(reqIsCfg), .reqIsData(reqIsData),
      .reqIsIdent(reqIsIdent), .cfgValid(cfgValid), .cfgByte(cfgByte), .cfgLast(cfgLast),
      .outWordValid(outWordValid), .outWord(outWord), .outWordReady(outWordReady), .inWord(inWord),
      .inWordTake(inWordTake), .respValid(respValid), .respAck(respAck), .respData(respData),
      .respLast(respLast), .stationAddr(stationAddr), .activeLayout(activeLayout),
      .useStoredLampValues(useStoredLampValues), .busLedGreen(busLedGreen), .regWord(regWord),
      .regWordValid(regWordValid), .regWordReady(regWordReady));
   dp_master_model i_master (.clk(clk), .outWordReady(outWordReady), .reqValid(reqValid),
      .reqAddr(reqAddr), .reqIsCfg(reqIsCfg), .reqIsData(reqIsData), .reqIsIdent(reqIsIdent),
      .cfgValid(cfgValid), .cfgByte(cfgByte), .cfgLast(cfgLast), .outWordValid(outWordValid),
      .outWord(outWord));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samplesChecked++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic conclude();
      if (mismatches == 0 && samplesChecked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   always @(posedge clk) begin
      if (regWordValid && regWordReady) begin
         chk(regWord, 16'h1000 + 16'(rxCount));
         rxCount++;
      end
      if (inWordTake) begin
         takes++;
         inWord <= inWord + 16'h0001;
      end
   end
   task automatic getResp();
      nResp = 0;
      for (int i = 0; i < 12; i++) begin
         @(posedge clk);
         if (respValid) begin
            if (nResp == 0) firstData = respData;
            nResp++;
            lastAck = respAck;
            if (respLast) break;
         end
      end
      @(posedge clk);
   endtask
   task automatic identCheck();
      chk(16'(stationAddr), 16'(ST));
      i_master.request(3'b001, ST);
      getResp();
      chk(firstData, SLAVE_IDENT);
      i_master.request(3'b010, ST + 7'h01);
      getResp();
      chk(16'(nResp), 16'h0000);
      i_master.request(3'b010, ST);
      getResp();
      chk(16'(nResp), 16'h0001);
      chk(16'(lastAck), 16'h0000);
      chk(16'(busLedGreen), 16'h0000);
   endtask
   task automatic setLayout(input logic [7:0] b[5], input int n, input logic [1:0] exp);
      i_master.configure(ST, b, n);
      repeat (4) @(posedge clk);
      chk(16'(activeLayout), 16'(exp));
      chk(16'(useStoredLampValues), 16'(exp == LAYOUT_SHORT));
   endtask
   task automatic exchange(input int nOut);
      int rx0;
      rx0 = rxCount;
      takes = 0;
      i_master.request(3'b010, ST);
      getResp();
      chk(16'(nResp), 16'h0005);
      chk(16'(takes), 16'h0005);
      regWordReady <= 1'b0;
      fork
         i_master.sendWords(nOut);
         begin
            repeat (30) @(posedge clk);
            chk(16'(outWordReady), 16'h0000);
            regWordReady <= 1'b1;
         end
      join
      repeat (14) @(posedge clk);
      chk(16'(rxCount - rx0), 16'(nOut));
      chk(16'(busLedGreen), 16'h0001);
   endtask
   task automatic layoutCheck();
      setLayout('{8'hD4, 8'hEB, 8'hE0, 8'h00, 8'h00}, 3, LAYOUT_NONE);
      setLayout('{8'hD4, 8'hEB, 8'hEB, 8'hEB, 8'hE0}, 5, LAYOUT_FULL);
      exchange(37);
      setLayout('{8'hD4, 8'hE0, 8'hEB, 8'h00, 8'h00}, 3, LAYOUT_SHORT);
      exchange(13);
   endtask
   task automatic addrCheck();
      addrSwitch <= ST + 7'h02;
      repeat (10) @(posedge clk);
      chk(16'(stationAddr), 16'(ST));
      i_master.request(3'b001, ST + 7'h02);
      getResp();
      chk(16'(nResp), 16'h0000);
      rst_n <= 1'b0;
      @(posedge clk);
      chk(16'(busLedGreen), 16'h0000);
      rst_n <= 1'b1;
      repeat (6) @(posedge clk);
      chk(16'(stationAddr), 16'(ST + 7'h02));
      chk(16'(activeLayout), 16'(LAYOUT_NONE));
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      #300000;
      mismatches++;
      conclude();
   end
   initial begin
      rst_n = 1'b0;
      addrSwitch = ST;
      inWord = 16'h2000;
      regWordReady = 1'b1;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (6) @(posedge clk);
      identCheck();
      layoutCheck();
      addrCheck();
      conclude();
   end
endmodule
